// *** design/nfc_pkg.sv ***
// constants, types and command codes of the host nand sequencer
// assumes an x8 nand part with on-chip ecc and 2112-byte pages on its pins
// Behaviour
// - only defined command codes ever issued
// - while busy only 70h or FFh
// - after 80h only 85h, 10h or FFh
// - pages of a block programmed ascending
// - main and spare of sector together
// - bytes of other sectors sent as ones
// - never erase a bad block
// - scan after install, exclude bad blocks
// - marker byte 00h means bad block
package nfc_pkg;
	localparam int          CLK_NS     = 25;
	localparam int          T_WB_NS    = 100;
	localparam int          WB_CYC     = (T_WB_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [11:0] PAGE_BYTES = 12'h840;
	localparam logic [11:0] LAST_BYTE  = 12'h83F;
	localparam logic [11:0] BB_COL     = 12'h800;
	localparam logic [11:0] ADDR_LONG  = 12'h004;
	localparam logic [11:0] ADDR_SHORT = 12'h002;
	localparam int          NUM_BLOCKS = 1024;
	localparam int          MIN_VALID  = 1004;
	localparam logic [10:0] MAX_BAD    = 11'(NUM_BLOCKS - MIN_VALID);
	localparam logic [9:0]  LAST_BLOCK = 10'h3FF;
	localparam logic [7:0]  BAD_MARK   = 8'h00;
	localparam logic [7:0]  CMD_READ   = 8'h00;
	localparam logic [7:0]  CMD_RD_GO  = 8'h30;
	localparam logic [7:0]  CMD_LOAD   = 8'h80;
	localparam logic [7:0]  CMD_PR_GO  = 8'h10;
	localparam logic [7:0]  CMD_ERASE  = 8'h60;
	localparam logic [7:0]  CMD_ER_GO  = 8'hD0;
	localparam logic [7:0]  CMD_STATUS = 8'h70;
	localparam logic [7:0]  CMD_RESET  = 8'hFF;
	localparam int          ST_FAIL    = 0;
	localparam int          ST_REWRITE = 3;
	localparam int          ST_READY   = 6;
	localparam int          ST_NOWP    = 7;

	typedef enum logic [2:0] {
		OP_NONE  = 3'h0,
		OP_READ  = 3'h1,
		OP_PROG  = 3'h2,
		OP_ERASE = 3'h3,
		OP_STAT  = 3'h4,
		OP_RST   = 3'h5,
		OP_SCAN  = 3'h6
	} nfc_op_t;

	typedef enum logic [2:0] {
		K_CMD   = 3'h0,
		K_ADDR4 = 3'h1,
		K_ADDR2 = 3'h2,
		K_DOUT  = 3'h3,
		K_WAIT  = 3'h4,
		K_POLL  = 3'h5,
		K_DIN   = 3'h6,
		K_END   = 3'h7
	} nfc_kind_t;

	typedef struct packed {
		nfc_kind_t  kind;
		logic [7:0] val;
	} nfc_act_t;

	typedef struct packed {
		nfc_op_t    op;
		logic [9:0] block;
		logic [5:0] page;
		logic [1:0] sector;
	} nfc_req_t;

	typedef struct packed {
		logic refused;
		logic fail;
		logic rewrite;
		logic protect;
	} nfc_res_t;

	typedef struct packed {
		logic       ce_n;
		logic       cle;
		logic       ale;
		logic       we_n;
		logic       re_n;
		logic       wp_n;
		logic       io_oe;
		logic [7:0] io_out;
	} nfc_pins_t;
endpackage : nfc_pkg

// *** design/nfc_host.sv ***
// host sequencer: power-up reset, bad-block scan, page read, sector program, erase
// assumes io_in and ready_busy_n already synchronous to clk_sys; wire built outside
module nfc_host (
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	input  wire logic              req_valid,
	input  wire nfc_pkg::nfc_req_t req,
	output logic                   req_ready,
	input  wire logic [7:0]        wr_data,
	input  wire logic              wr_valid,
	output logic                   wr_ready,
	output logic [7:0]             rd_data,
	output logic                   rd_valid,
	output logic                   done,
	output nfc_pkg::nfc_res_t      result,
	output logic                   init_done,
	output logic [10:0]            bad_count,
	output logic                   bad_excess,
	output nfc_pkg::nfc_pins_t     pins,
	input  wire logic [7:0]        io_in,
	input  wire logic              ready_busy_n
);
	nfc_pkg::nfc_op_t   op_q;
	nfc_pkg::nfc_req_t  cur_q;
	nfc_pkg::nfc_act_t  act_w;
	nfc_pkg::nfc_pins_t pins_q;
	nfc_pkg::nfc_res_t  res_q;
	logic [3:0]         stage_q;
	logic [1:0]         sub_q;
	logic [11:0]        cnt_q;
	logic [11:0]        col_q;
	logic [11:0]        last_w;
	logic [7:0]         stat_q;
	logic [7:0]         byte_w;
	logic [7:0]         rd_data_q;
	logic [7:0]         mark_q;
	logic               rd_valid_q;
	logic               done_q;
	logic               req_ready_q;
	logic               wr_ready_q;
	logic               init_q;
	logic               take_w;
	logic               end_w;
	logic               bad_tab [nfc_pkg::NUM_BLOCKS];
	logic [5:0]         next_pg [nfc_pkg::NUM_BLOCKS];
	logic               pg_used [nfc_pkg::NUM_BLOCKS];
	logic [10:0]        bad_q;
	logic               excess_q;

	function automatic nfc_pkg::nfc_act_t script(nfc_pkg::nfc_op_t op, logic [3:0] st);
		nfc_pkg::nfc_act_t a;
		a = '{kind: nfc_pkg::K_END, val: 8'h00};
		unique case (op)
			nfc_pkg::OP_READ, nfc_pkg::OP_SCAN: begin
				unique case (st)
					4'h0:    a = '{nfc_pkg::K_CMD, nfc_pkg::CMD_READ};
					4'h1:    a = '{nfc_pkg::K_ADDR4, 8'h00};
					4'h2:    a = '{nfc_pkg::K_CMD, nfc_pkg::CMD_RD_GO};
					4'h3:    a = '{nfc_pkg::K_WAIT, 8'h00};
					4'h4:    a = '{nfc_pkg::K_CMD, nfc_pkg::CMD_STATUS};
					4'h5:    a = '{nfc_pkg::K_POLL, 8'h00};
					4'h6:    a = '{nfc_pkg::K_CMD, nfc_pkg::CMD_READ};
					4'h7:    a = '{nfc_pkg::K_DIN, 8'h00};
					default: a = '{nfc_pkg::K_END, 8'h00};
				endcase
			end
			nfc_pkg::OP_PROG: begin
				unique case (st)
					4'h0:    a = '{nfc_pkg::K_WAIT, 8'h00};
					4'h1:    a = '{nfc_pkg::K_CMD, nfc_pkg::CMD_LOAD};
					4'h2:    a = '{nfc_pkg::K_ADDR4, 8'h00};
					4'h3:    a = '{nfc_pkg::K_DOUT, 8'h00};
					4'h4:    a = '{nfc_pkg::K_CMD, nfc_pkg::CMD_PR_GO};
					4'h5:    a = '{nfc_pkg::K_WAIT, 8'h00};
					4'h6:    a = '{nfc_pkg::K_CMD, nfc_pkg::CMD_STATUS};
					4'h7:    a = '{nfc_pkg::K_POLL, 8'h00};
					default: a = '{nfc_pkg::K_END, 8'h00};
				endcase
			end
			nfc_pkg::OP_ERASE: begin
				unique case (st)
					4'h0:    a = '{nfc_pkg::K_WAIT, 8'h00};
					4'h1:    a = '{nfc_pkg::K_CMD, nfc_pkg::CMD_ERASE};
					4'h2:    a = '{nfc_pkg::K_ADDR2, 8'h00};
					4'h3:    a = '{nfc_pkg::K_CMD, nfc_pkg::CMD_ER_GO};
					4'h4:    a = '{nfc_pkg::K_WAIT, 8'h00};
					4'h5:    a = '{nfc_pkg::K_CMD, nfc_pkg::CMD_STATUS};
					4'h6:    a = '{nfc_pkg::K_POLL, 8'h00};
					default: a = '{nfc_pkg::K_END, 8'h00};
				endcase
			end
			nfc_pkg::OP_STAT: begin
				unique case (st)
					4'h0:    a = '{nfc_pkg::K_CMD, nfc_pkg::CMD_STATUS};
					4'h1:    a = '{nfc_pkg::K_POLL, 8'h00};
					default: a = '{nfc_pkg::K_END, 8'h00};
				endcase
			end
			nfc_pkg::OP_RST: begin
				unique case (st)
					4'h0:    a = '{nfc_pkg::K_WAIT, 8'h00};
					4'h1:    a = '{nfc_pkg::K_CMD, nfc_pkg::CMD_RESET};
					4'h2:    a = '{nfc_pkg::K_WAIT, 8'h00};
					4'h3:    a = '{nfc_pkg::K_CMD, nfc_pkg::CMD_STATUS};
					4'h4:    a = '{nfc_pkg::K_POLL, 8'h00};
					default: a = '{nfc_pkg::K_END, 8'h00};
				endcase
			end
			default: a = '{nfc_pkg::K_END, 8'h00};
		endcase
		return a;
	endfunction : script

	// byte belongs to the chosen sector, main or spare part
	function automatic logic in_sector(logic [11:0] idx, logic [1:0] sec);
		return idx[11] ? (idx[5:4] == sec) : (idx[10:9] == sec);
	endfunction : in_sector

	function automatic logic [7:0] addr_byte(logic [1:0] idx, logic [11:0] col,
						nfc_pkg::nfc_req_t r);
		unique case (idx)
			2'h0: return col[7:0];
			2'h1: return {4'h0, col[11:8]};
			2'h2: return {r.block[1:0], r.page};
			2'h3: return r.block[9:2];
		endcase
	endfunction : addr_byte

	always_comb begin
		act_w  = script(op_q, stage_q);
		end_w  = (op_q != nfc_pkg::OP_NONE) && (act_w.kind == nfc_pkg::K_END);
		take_w = wr_valid && wr_ready_q;
		unique case (act_w.kind)
			nfc_pkg::K_CMD:   last_w = 12'h000;
			nfc_pkg::K_ADDR4: last_w = nfc_pkg::ADDR_LONG - 12'h001;
			nfc_pkg::K_ADDR2: last_w = nfc_pkg::ADDR_SHORT - 12'h001;
			nfc_pkg::K_DIN:   last_w = (op_q == nfc_pkg::OP_SCAN) ? 12'h000 : nfc_pkg::LAST_BYTE;
			default:          last_w = nfc_pkg::LAST_BYTE;
		endcase
		unique case (act_w.kind)
			nfc_pkg::K_CMD:   byte_w = act_w.val;
			nfc_pkg::K_ADDR4: byte_w = addr_byte(cnt_q[1:0], col_q, cur_q);
			nfc_pkg::K_ADDR2: byte_w = addr_byte(cnt_q[1:0] + 2'h2, col_q, cur_q);
			default:          byte_w = in_sector(cnt_q, cur_q.sector) ? wr_data : 8'hFF;
		endcase
	end

	// sequencer and pin cycles
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			op_q        <= nfc_pkg::OP_RST;
			cur_q       <= '0;
			stage_q     <= 4'h0;
			sub_q       <= 2'h0;
			cnt_q       <= 12'h000;
			col_q       <= 12'h000;
			stat_q      <= 8'h00;
			mark_q      <= 8'hFF;
			rd_data_q   <= 8'h00;
			rd_valid_q  <= 1'b0;
			done_q      <= 1'b0;
			res_q       <= '0;
			req_ready_q <= 1'b0;
			wr_ready_q  <= 1'b0;
			init_q      <= 1'b0;
			pins_q      <= '{ce_n: 1'b0, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
					 wp_n: 1'b0, io_oe: 1'b0, io_out: 8'h00};
		end else begin
			done_q     <= 1'b0;
			rd_valid_q <= 1'b0;
			if (op_q == nfc_pkg::OP_NONE) begin
				if (req_valid && req_ready_q) begin
					cur_q   <= req;
					stage_q <= 4'h0;
					cnt_q   <= 12'h000;
					col_q   <= 12'h000;
					res_q   <= '0;
					if (!(req.op inside {nfc_pkg::OP_READ, nfc_pkg::OP_PROG,
							nfc_pkg::OP_ERASE, nfc_pkg::OP_STAT, nfc_pkg::OP_RST})
					    || (bad_tab[req.block] && req.op inside {nfc_pkg::OP_READ,
							nfc_pkg::OP_PROG, nfc_pkg::OP_ERASE})
					    || (req.op == nfc_pkg::OP_PROG && pg_used[req.block]
							&& req.page < next_pg[req.block])) begin
						done_q        <= 1'b1;
						res_q.refused <= 1'b1;
					end else begin
						op_q        <= req.op;
						req_ready_q <= 1'b0;
						pins_q.wp_n <= req.op inside {nfc_pkg::OP_PROG, nfc_pkg::OP_ERASE};
					end
				end
			end else begin
				unique case (act_w.kind)
					nfc_pkg::K_CMD, nfc_pkg::K_ADDR4, nfc_pkg::K_ADDR2, nfc_pkg::K_DOUT: begin
						unique case (sub_q)
							2'h0: begin
								if (act_w.kind != nfc_pkg::K_DOUT
								    || !in_sector(cnt_q, cur_q.sector) || take_w) begin
									pins_q.io_out <= byte_w;
									pins_q.io_oe  <= 1'b1;
									pins_q.cle    <= act_w.kind == nfc_pkg::K_CMD;
									pins_q.ale    <= act_w.kind inside {nfc_pkg::K_ADDR4,
												nfc_pkg::K_ADDR2};
									pins_q.we_n   <= 1'b0;
									sub_q         <= 2'h1;
									wr_ready_q    <= 1'b0;
								end else begin
									wr_ready_q <= 1'b1;
								end
							end
							2'h1: begin
								pins_q.we_n <= 1'b1;
								sub_q       <= 2'h2;
							end
							default: begin
								pins_q.cle <= 1'b0;
								pins_q.ale <= 1'b0;
								sub_q      <= 2'h0;
								if (cnt_q == last_w) begin
									cnt_q   <= 12'h000;
									stage_q <= stage_q + 4'h1;
								end else begin
									cnt_q <= cnt_q + 12'h001;
								end
							end
						endcase
					end
					nfc_pkg::K_WAIT: begin
						pins_q.io_oe <= 1'b0;
						if (cnt_q >= 12'(nfc_pkg::WB_CYC) && ready_busy_n) begin
							cnt_q   <= 12'h000;
							stage_q <= stage_q + 4'h1;
						end else if (cnt_q < 12'(nfc_pkg::WB_CYC)) begin
							cnt_q <= cnt_q + 12'h001;
						end
					end
					nfc_pkg::K_POLL, nfc_pkg::K_DIN: begin
						pins_q.io_oe <= 1'b0;
						unique case (sub_q)
							2'h0: begin
								pins_q.re_n <= 1'b0;
								sub_q       <= 2'h1;
							end
							2'h1: sub_q <= 2'h2;
							2'h2: begin
								pins_q.re_n <= 1'b1;
								sub_q       <= 2'h3;
								if (act_w.kind == nfc_pkg::K_POLL) begin
									stat_q <= io_in;
								end else if (op_q == nfc_pkg::OP_SCAN) begin
									mark_q <= io_in;
								end else begin
									rd_data_q  <= io_in;
									rd_valid_q <= 1'b1;
								end
							end
							default: begin
								sub_q <= 2'h0;
								if (act_w.kind == nfc_pkg::K_POLL) begin
									// repeat 70h-mode reads only, until ready; OP_STAT reads once
									if (stat_q[nfc_pkg::ST_READY] || op_q == nfc_pkg::OP_STAT) begin
										stage_q <= stage_q + 4'h1;
									end
								end else if (cnt_q == last_w) begin
									cnt_q   <= 12'h000;
									stage_q <= stage_q + 4'h1;
								end else begin
									cnt_q <= cnt_q + 12'h001;
								end
							end
						endcase
					end
					default: begin
						stage_q     <= 4'h0;
						cnt_q       <= 12'h000;
						pins_q.wp_n <= 1'b0;
						if (op_q == nfc_pkg::OP_RST && !init_q) begin
							op_q        <= nfc_pkg::OP_SCAN;
							cur_q       <= '0;
							col_q       <= nfc_pkg::BB_COL;
						end else if (op_q == nfc_pkg::OP_SCAN) begin
							if (cur_q.block == nfc_pkg::LAST_BLOCK) begin
								op_q        <= nfc_pkg::OP_NONE;
								init_q      <= 1'b1;
								req_ready_q <= 1'b1;
							end else begin
								cur_q.block <= cur_q.block + 10'h001;
							end
						end else begin
							op_q          <= nfc_pkg::OP_NONE;
							req_ready_q   <= 1'b1;
							done_q        <= 1'b1;
							res_q.fail    <= stat_q[nfc_pkg::ST_FAIL];
							res_q.rewrite <= stat_q[nfc_pkg::ST_REWRITE];
							res_q.protect <= !stat_q[nfc_pkg::ST_NOWP];
						end
					end
				endcase
			end
		end
	end

	// bad-block and page-order tables, filled by the scan before any user access
	always_ff @(posedge clk_sys) begin
		if (end_w && op_q == nfc_pkg::OP_SCAN) begin
			bad_tab[cur_q.block] <= (mark_q == nfc_pkg::BAD_MARK);
			pg_used[cur_q.block] <= 1'b0;
		end else if (end_w && op_q == nfc_pkg::OP_ERASE) begin
			pg_used[cur_q.block] <= 1'b0;
			if (stat_q[nfc_pkg::ST_FAIL]) begin
				bad_tab[cur_q.block] <= 1'b1;
			end
		end else if (end_w && op_q == nfc_pkg::OP_PROG) begin
			pg_used[cur_q.block] <= 1'b1;
			next_pg[cur_q.block] <= cur_q.page;
			if (stat_q[nfc_pkg::ST_FAIL]) begin
				bad_tab[cur_q.block] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			bad_q    <= 11'h000;
			excess_q <= 1'b0;
		end else begin
			if (end_w && ((op_q == nfc_pkg::OP_SCAN && mark_q == nfc_pkg::BAD_MARK)
			    || (op_q inside {nfc_pkg::OP_PROG, nfc_pkg::OP_ERASE}
				&& stat_q[nfc_pkg::ST_FAIL] && !bad_tab[cur_q.block]))) begin
				bad_q <= bad_q + 11'h001;
			end
			excess_q <= bad_q > nfc_pkg::MAX_BAD;
		end
	end

	assign req_ready  = req_ready_q;
	assign wr_ready   = wr_ready_q;
	assign rd_data    = rd_data_q;
	assign rd_valid   = rd_valid_q;
	assign done       = done_q;
	assign result     = res_q;
	assign init_done  = init_q;
	assign bad_count  = bad_q;
	assign bad_excess = excess_q;
	assign pins       = pins_q;
endmodule : nfc_host

// *** verif/nfc_host_asserts.sv ***
// checker of the host nand sequencer, watching its top-level ports only
// assumes one clock domain and pins that change only on clk_sys edges
module nfc_host_asserts (
	input wire logic               clk_sys,
	input wire logic               sys_rst,
	input wire logic               req_valid,
	input wire nfc_pkg::nfc_req_t  req,
	input wire logic               req_ready,
	input wire logic               init_done,
	input wire logic [10:0]        bad_count,
	input wire logic               bad_excess,
	input wire nfc_pkg::nfc_pins_t pins,
	input wire logic               ready_busy_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic        we_q;
	logic        prog_q;
	logic [7:0]  last_q;
	logic [7:0]  prev_q;
	logic [11:0] col_q;
	logic [1:0]  sec_q;
	logic        cmd;
	logic        dat;
	logic        in_sec;
	assign cmd = pins.we_n & ~we_q & pins.cle;
	assign dat = pins.we_n & ~we_q & ~pins.cle & ~pins.ale;
	assign in_sec = col_q[11] ? (col_q[5:4] == sec_q) : (col_q[10:9] == sec_q);
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			we_q   <= 1'b1;
			last_q <= 8'h00;
			prev_q <= 8'h00;
		end else begin
			we_q <= pins.we_n;
			if (cmd) begin
				last_q <= pins.io_out;
				prev_q <= last_q;
			end
		end
	end
	// column walk of the page being loaded
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			prog_q <= 1'b0;
			col_q  <= 12'h000;
			sec_q  <= 2'h0;
		end else begin
			if (req_valid && req_ready && req.op == nfc_pkg::OP_PROG)
				sec_q <= req.sector;
			if (cmd) begin
				prog_q <= (pins.io_out == 8'h80);
				col_q  <= 12'h000;
			end else if (dat)
				col_q <= col_q + 12'h001;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence s_resume;
		cmd && pins.io_out == 8'h00 && last_q == 8'h70 && prev_q == 8'h30;
	endsequence
	sequence s_pe_start;
		cmd && pins.io_out inside {8'h80, 8'h60};
	endsequence
	cmd_legal_a: assert property (cmd |-> pins.io_out inside
		{8'h00, 8'h30, 8'h80, 8'h10, 8'h60, 8'hD0, 8'h70, 8'hFF}) else $error("undefined command");
	busy_cmd_a: assert property (cmd && !$past(ready_busy_n) |->
		pins.io_out inside {8'h70, 8'hFF}) else $error("command while busy");
	after_load_a: assert property (cmd && last_q == 8'h80 |->
		pins.io_out inside {8'h85, 8'h10, 8'hFF}) else $error("bad command after load");
	fill_ones_a: assert property (prog_q && dat && !in_sec |-> pins.io_out == 8'hFF)
		else $error("foreign sector byte not ones");
	wp_raised_a: assert property (s_pe_start |-> pins.wp_n)
		else $error("program or erase with protect low");
	resume_read_a: assert property (s_resume |-> !pins.ale [*8])
		else $error("address after status resume");
	ready_init_a: assert property (req_ready |-> init_done)
		else $error("request taken before scan");
	bad_excess_a: assert property ($stable(bad_count) |->
		bad_excess == (bad_count > 11'h014)) else $error("excess flag wrong");
endmodule : nfc_host_asserts

bind nfc_host nfc_host_asserts i_nfc_host_asserts (.clk_sys, .sys_rst, .req_valid, .req,
	.req_ready, .init_done, .bad_count, .bad_excess, .pins, .ready_busy_n);

// *** verif/nfc_dev_model.sv ***
// behavioural nand device: one page buffer, status, busy line, one bad block
// assumes pins come from the host sequencer; io_in is the bus seen by the host
module nfc_dev_model #(
	parameter logic [9:0] BAD_BLK = 10'h005
) (
	input  wire logic               clk_sys,
	input  wire nfc_pkg::nfc_pins_t pins,
	input  wire logic               fail_set,
	output logic [7:0]              io_in,
	output logic                    ready_busy_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0]  mem [0:2111];
	logic [7:0]  last_q;
	logic [7:0]  out_b;
	logic [11:0] col_q;
	logic [9:0]  blk_q;
	logic        stat_q;
	logic        fail_q;
	logic        pe_q;
	int          na_q;
	int          busy_q;
	initial begin
		for (int i = 0; i < 2112; i++) mem[i] = 8'(i) ^ 8'h5A;
		{last_q, col_q, blk_q, stat_q, fail_q, pe_q, na_q} = '0;
		busy_q = 40;
	end
	assign ready_busy_n = (busy_q == 0);
	assign out_b = stat_q ? {pins.wp_n, ready_busy_n, ready_busy_n, 4'h0, fail_q} :
		(col_q == 12'h800 && blk_q == BAD_BLK) ? 8'h00 : mem[col_q];
	// released bus shows the inverse
	assign io_in = pins.re_n ? ~out_b : out_b;
	always @(posedge clk_sys)
		if (busy_q > 0) busy_q <= (pe_q && !pins.wp_n) ? 0 : busy_q - 1;
	always @(posedge pins.re_n)
		if (!stat_q && col_q < 12'h83F) col_q++;
	always @(posedge pins.we_n) begin
		if (pins.cle === 1'b1) begin
			if (busy_q == 0 || pins.io_out inside {8'h70, 8'hFF}) begin
				case (pins.io_out)
					8'h70: stat_q = 1'b1;
					8'h00: begin stat_q = 1'b0; na_q = 0; end
					8'h30: begin busy_q = 5; pe_q = 1'b0; fail_q = 1'b0; end
					8'h60: na_q = 2;
					8'h80: na_q = 0;
					8'hFF: begin busy_q = 3; pe_q = 1'b0; stat_q = 1'b0; end
					8'h10, 8'hD0: if (pins.wp_n && last_q inside {8'h80, 8'h60}) begin
						busy_q = 6;
						pe_q = 1'b1;
						fail_q = fail_set;
					end
					default: ;
				endcase
				last_q = pins.io_out;
			end
		end else if (pins.ale === 1'b1) begin
			case (na_q)
				0: col_q[7:0] = pins.io_out;
				1: col_q[11:8] = pins.io_out[3:0];
				2: blk_q[1:0] = pins.io_out[7:6];
				3: blk_q[9:2] = pins.io_out;
				default: ;
			endcase
			na_q++;
		end else if (pins.io_oe === 1'b1 && pins.ale === 1'b0 && pins.cle === 1'b0
			     && col_q < 12'h840) begin
			// io_oe gate keeps the reset-time rise of we_n from landing a byte
			mem[col_q] = pins.io_out;
			col_q++;
		end
	end
endmodule : nfc_dev_model

// *** verif/tb_nfc_host.sv ***
// self-checking bench of the host nand sequencer against the device model
// assumes the checker is bound to nfc_host from its own file
module tb_nfc_host;
	timeunit 1ns;
	timeprecision 100ps;
	logic               clk_sys, sys_rst, req_valid, wr_valid, fail_set, req_ready, wr_ready;
	logic               rd_valid, done, init_done, bad_excess, ready_busy_n;
	logic [7:0]         wr_data, rd_data, io_in, first_b, last_b;
	logic [10:0]        bad_count;
	nfc_pkg::nfc_req_t  req;
	nfc_pkg::nfc_res_t  result;
	nfc_pkg::nfc_pins_t pins;
	int                 n_fail, checked, nrd;
	nfc_host i_nfc_host (.clk_sys, .sys_rst, .req_valid, .req, .req_ready, .wr_data, .wr_valid,
		.wr_ready, .rd_data, .rd_valid, .done, .result, .init_done, .bad_count, .bad_excess,
		.pins, .io_in, .ready_busy_n);
	nfc_dev_model i_nfc_dev_model (.clk_sys, .pins, .fail_set, .io_in, .ready_busy_n);
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : finish_test
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : check
	task automatic run_op(input nfc_pkg::nfc_op_t op, input logic [9:0] blk,
		input logic [5:0] pg, input logic [1:0] sec);
		int n;
		req <= '{op, blk, pg, sec};
		req_valid <= 1'b1;
		wr_valid <= (op == nfc_pkg::OP_PROG);
		do @(posedge clk_sys); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		nrd = 0;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
			if (rd_valid === 1'b1) begin
				if (nrd == 0) first_b = rd_data;
				last_b = rd_data;
				nrd++;
			end
		end while (done !== 1'b1 && n < 30000);
		wr_valid <= 1'b0;
		check(16'(n < 30000), 16'h0001);
	endtask : run_op
	task automatic t_init();
		int n;
		n = 0;
		while (init_done !== 1'b1 && n < 60000) begin
			@(posedge clk_sys);
			n++;
		end
		repeat (2) @(posedge clk_sys);
		check(16'(init_done), 16'h0001);
		check(16'(bad_count), 16'h0001);
		check(16'(bad_excess), 16'h0000);
		check(16'(req_ready), 16'h0001);
	endtask : t_init
	task automatic t_read();
		run_op(nfc_pkg::OP_READ, 10'h002, 6'h00, 2'h0);
		check(16'(result.refused), 16'h0000);
		check(16'(nrd), 16'h0840);
		check(16'(first_b), 16'h005A);
		check(16'(last_b), 16'h0065);
	endtask : t_read
	task automatic t_bad();
		run_op(nfc_pkg::OP_READ, 10'h005, 6'h00, 2'h0);
		check(16'(result.refused), 16'h0001);
		run_op(nfc_pkg::OP_ERASE, 10'h005, 6'h00, 2'h0);
		check(16'(result.refused), 16'h0001);
	endtask : t_bad
	task automatic t_prog();
		logic in_s;
		run_op(nfc_pkg::OP_PROG, 10'h003, 6'h03, 2'h2);
		check(16'({result.refused, result.fail}), 16'h0000);
		for (int c = 0; c < 2112; c++) begin
			in_s = (c < 2048) ? (c / 512 == 2) : ((c - 2048) / 16 == 2);
			check(16'(i_nfc_dev_model.mem[c]), in_s ? 16'h00A5 : 16'h00FF);
		end
		run_op(nfc_pkg::OP_PROG, 10'h003, 6'h01, 2'h0);
		check(16'(result.refused), 16'h0001);
		run_op(nfc_pkg::OP_PROG, 10'h003, 6'h03, 2'h1);
		check(16'(result.refused), 16'h0000);
		check(16'(i_nfc_dev_model.mem[2064]), 16'h00A5);
	endtask : t_prog
	task automatic t_misc();
		run_op(nfc_pkg::OP_STAT, 10'h000, 6'h00, 2'h0);
		check(16'({result.refused, result.fail, result.rewrite, result.protect}), 16'h0001);
		run_op(nfc_pkg::OP_RST, 10'h000, 6'h00, 2'h0);
		check(16'(result.refused), 16'h0000);
		run_op(nfc_pkg::OP_ERASE, 10'h004, 6'h00, 2'h0);
		check(16'(result.refused), 16'h0000);
		run_op(nfc_pkg::OP_SCAN, 10'h000, 6'h00, 2'h0);
		check(16'(result.refused), 16'h0001);
		run_op(nfc_pkg::OP_NONE, 10'h000, 6'h00, 2'h0);
		check(16'(result.refused), 16'h0001);
	endtask : t_misc
	task automatic t_fail();
		fail_set <= 1'b1;
		run_op(nfc_pkg::OP_ERASE, 10'h009, 6'h00, 2'h0);
		check(16'(result.fail), 16'h0001);
		check(16'(bad_count), 16'h0002);
		fail_set <= 1'b0;
		run_op(nfc_pkg::OP_PROG, 10'h009, 6'h00, 2'h0);
		check(16'(result.refused), 16'h0001);
	endtask : t_fail
	initial begin
		{n_fail, checked, nrd} = '0;
		{sys_rst, req_valid, wr_valid, fail_set} = 4'h8;
		req = '0;
		wr_data = 8'hA5;
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_init();
		t_read();
		t_bad();
		t_prog();
		t_misc();
		t_fail();
		finish_test();
	end
	initial begin
		#2_400_000;
		n_fail++;
		finish_test();
	end
endmodule : tb_nfc_host
